// file: scb_unit.sv
// Shift, conditional move and lanewise byte compare operate slice.
// Assumes the pipeline presents decoded operands for one cycle with
// issue_valid and takes the registered result one cycle later.
`timescale 1ns/1ps
// Behaviour
// - Passing test copies second operand to destination
// - Failing test leaves destination unchanged
// - Eight tests: zero, sign and low bit
// - Logical shifts use count bits five down to zero
// - Logical shifts fill vacated bits with zero
// - Arithmetic right shift by zero to 63
// - Arithmetic shift fills with sign bit
// - Count comes from register or literal
// - Eight byte lanes compared in parallel
// - Lane bit set when first byte unsigned greater-equal
// - Compare result bits above seven are zero
// - No operation raises an exception
module scb_unit
  import scb_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Issue side
  input wire logic issue_valid,
  input wire logic [3:0] op_select,
  input wire logic [63:0] first_source_operand,
  input wire logic [63:0] second_source_operand,
  input wire logic [7:0] literal_value,
  input wire logic use_literal,
  input wire logic [63:0] destination_old,
  // Result side
  output logic result_valid,
  output logic destination_write,
  output logic [63:0] destination_register,
  output logic exception_flag
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [63:0] result;
  } scb_state_t;

  scb_state_t st_r;
  scb_state_t st_nxt;
  logic [63:0] operand_b;
  logic [5:0] count;
  logic [7:0] lane_mask;
  logic cond_pass;
  scb_op_t op;

  // Decodes whether a code is one of the eight conditional moves.
  function automatic logic is_cond_move(input logic [3:0] code);
    is_cond_move = (code <= 4'h7);
  endfunction

  // Evaluates the condition chosen by the code on the first operand.
  function automatic logic test_holds(input logic [3:0] code,
                                      input logic [63:0] a);
    logic zero;
    logic neg;
    zero = (a == 64'h0000_0000_0000_0000);
    neg = a[SCB_SIGN_BIT];
    case (code)
      4'h0: test_holds = zero;
      4'h1: test_holds = !zero;
      4'h2: test_holds = neg;
      4'h3: test_holds = neg || zero;
      4'h4: test_holds = !neg && !zero;
      4'h5: test_holds = !neg;
      4'h6: test_holds = !a[SCB_LOW_BIT];
      4'h7: test_holds = a[SCB_LOW_BIT];
      default: test_holds = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Operand selection
  // ----------------------------------------------------------------
  // The literal widens with zeros, so a literal compare or move operand
  // has no ones above bit 7; the count takes only bits five down to zero.
  always_comb begin
    operand_b = use_literal ? {SCB_HIGH_ZERO, literal_value}
                            : second_source_operand;
    count = operand_b[SCB_CNT_W-1:0];
    op = scb_op_t'(op_select);
    cond_pass = test_holds(op_select, first_source_operand);
  end

  // ----------------------------------------------------------------
  // Byte lanes
  // ----------------------------------------------------------------
  // All eight lanes work side by side; no carry joins them.
  genvar gi;
  generate
    for (gi = 0; gi < SCB_LANES; gi = gi + 1) begin : g_lane
      scb_lane_cmp u_lane (
        .lane_a(first_source_operand[gi*SCB_LANE_W +: SCB_LANE_W]),
        .lane_b(operand_b[gi*SCB_LANE_W +: SCB_LANE_W]),
        .lane_ge(lane_mask[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // A failed move still reports the old destination so that a
  // forwarding path sees the unchanged value.
  always_comb begin
    st_nxt = st_r;
    st_nxt.valid = issue_valid;
    st_nxt.write = 1'b0;
    if (issue_valid) begin
      st_nxt.write = 1'b1;
      case (op)
        SCB_OP_SHIFT_LEFT_ZERO: begin
          st_nxt.result = first_source_operand << count;
        end
        SCB_OP_SHIFT_RIGHT_ZERO: begin
          st_nxt.result = first_source_operand >> count;
        end
        SCB_OP_SHIFT_RIGHT_SIGN: begin
          st_nxt.result = $signed(first_source_operand) >>> count;
        end
        SCB_OP_LANE_GE_COMPARE: begin
          st_nxt.result = {SCB_HIGH_ZERO, lane_mask};
        end
        default: begin
          if (is_cond_move(op_select) && cond_pass) begin
            st_nxt.result = operand_b;
          end else begin
            st_nxt.write = 1'b0;
            st_nxt.result = destination_old;
          end
        end
      endcase
    end
  end

  // Register the whole state at once.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_r <= '{valid: 1'b0, write: 1'b0, result: SCB_RESULT_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign result_valid = st_r.valid;
  assign destination_write = st_r.write;
  assign destination_register = st_r.result;
  assign exception_flag = 1'b0;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  a_move_pass_copy: assert property (
    issue_valid && is_cond_move(op_select) && cond_pass
    |=> destination_write && destination_register == $past(operand_b))
    else $error("Passing move did not copy the operand.");
  a_move_fail_keep: assert property (
    issue_valid && is_cond_move(op_select) && !cond_pass
    |=> !destination_write && destination_register == $past(destination_old))
    else $error("Failing move changed the destination.");
  a_test_sign_zero: assert property (
    issue_valid && op_select == 4'h4 && first_source_operand[63]
    |=> !destination_write)
    else $error("Greater than zero passed on a negative value.");
  a_left_shift_val: assert property (
    issue_valid && op == SCB_OP_SHIFT_LEFT_ZERO
    |=> destination_register ==
        ($past(first_source_operand) << $past(operand_b[5:0])))
    else $error("Left shift result wrong.");
  a_right_zero_fill: assert property (
    issue_valid && op == SCB_OP_SHIFT_RIGHT_ZERO && count != 6'h00
    |=> destination_register[63] == 1'b0)
    else $error("Right logical shift did not fill zero.");
  a_sign_fill_top: assert property (
    issue_valid && op == SCB_OP_SHIFT_RIGHT_SIGN
    |=> destination_register[63] == $past(first_source_operand[63]))
    else $error("Arithmetic shift lost the sign.");
  a_arith_shift_val: assert property (
    issue_valid && op == SCB_OP_SHIFT_RIGHT_SIGN && count == 6'h3F
    |=> destination_register == {64{$past(first_source_operand[63])}})
    else $error("Arithmetic shift by 63 wrong.");
  a_literal_count: assert property (
    issue_valid && use_literal && op == SCB_OP_SHIFT_RIGHT_ZERO
    |=> destination_register ==
        ($past(first_source_operand) >> $past(literal_value[5:0])))
    else $error("Literal count not used.");
  a_compare_high_zero: assert property (
    issue_valid && op == SCB_OP_LANE_GE_COMPARE
    |=> destination_register[63:8] == SCB_HIGH_ZERO && destination_write)
    else $error("Compare wrote nonzero high bits.");
  a_compare_equal_all: assert property (
    issue_valid && op == SCB_OP_LANE_GE_COMPARE
    && first_source_operand == operand_b
    |=> destination_register[7:0] == 8'hFF)
    else $error("Equal lanes not reported greater-equal.");
  a_no_exception: assert property (
    issue_valid |=> result_valid && !exception_flag)
    else $error("Operation did not complete cleanly.");

  c_move_taken: cover property (
    issue_valid && is_cond_move(op_select) && cond_pass ##1 result_valid);
  c_move_skipped: cover property (
    issue_valid && is_cond_move(op_select) && !cond_pass);
  c_sign_shift: cover property (
    issue_valid && op == SCB_OP_SHIFT_RIGHT_SIGN && first_source_operand[63]);
  c_compare_mixed: cover property (
    issue_valid && op == SCB_OP_LANE_GE_COMPARE
    && lane_mask != 8'h00 && lane_mask != 8'hFF);

endmodule

// file: scb_pkg.sv
// Shared constants and types for the shift, conditional move and byte
// compare datapath slice.
// Assumes a 64-bit integer operate pipeline with 8-bit literals.
package scb_pkg;

  // ----------------------------------------------------------------
  // Widths and field positions
  // ----------------------------------------------------------------
  localparam int unsigned SCB_XLEN = 64;
  localparam int unsigned SCB_LIT_W = 8;
  localparam int unsigned SCB_LANES = 8;
  localparam int unsigned SCB_LANE_W = 8;
  localparam int unsigned SCB_CNT_W = 6;
  localparam int unsigned SCB_SIGN_BIT = 63;
  localparam int unsigned SCB_LOW_BIT = 0;
  localparam int unsigned SCB_OP_W = 4;

  // ----------------------------------------------------------------
  // Reset value and zero padding
  // ----------------------------------------------------------------
  localparam logic [63:0] SCB_RESULT_RST = 64'h0000_0000_0000_0000;
  localparam logic [55:0] SCB_HIGH_ZERO = 56'h00_0000_0000_0000;

  // Operation select, one code per operate function.
  typedef enum logic [3:0] {
    SCB_OP_MOVE_IF_ZERO      = 4'h0,
    SCB_OP_MOVE_IF_NONZERO   = 4'h1,
    SCB_OP_MOVE_IF_LT        = 4'h2,
    SCB_OP_MOVE_IF_LE        = 4'h3,
    SCB_OP_MOVE_IF_GT        = 4'h4,
    SCB_OP_MOVE_IF_GE        = 4'h5,
    SCB_OP_MOVE_IF_LOW_CLEAR = 4'h6,
    SCB_OP_MOVE_IF_LOW_SET   = 4'h7,
    SCB_OP_SHIFT_LEFT_ZERO   = 4'h8,
    SCB_OP_SHIFT_RIGHT_ZERO  = 4'h9,
    SCB_OP_SHIFT_RIGHT_SIGN  = 4'hA,
    SCB_OP_LANE_GE_COMPARE   = 4'hB
  } scb_op_t;

endpackage

// file: scb_lane_cmp.sv
// One byte lane of the unsigned greater-or-equal compare.
// Assumes both bytes come from the same lane of the two operands.
`timescale 1ns/1ps
module scb_lane_cmp
  import scb_pkg::*;
(
  // Lane bytes
  input wire logic [7:0] lane_a,
  input wire logic [7:0] lane_b,
  // Lane verdict
  output logic lane_ge
);

  // ----------------------------------------------------------------
  // Carry out of a plus not b plus one
  // ----------------------------------------------------------------
  logic [8:0] sum;

  // The carry out is set exactly when a is not below b, unsigned.
  always_comb begin
    sum = {1'b0, lane_a} + {1'b0, ~lane_b} + 9'h001;
    lane_ge = sum[8];
  end

endmodule

// file: scb_pipe_model.sv
// Pipeline partner model: the destination entry the slice writes back.
// Assumes a write lands at the edge that ends the result cycle.
`timescale 1ns/1ps
module scb_pipe_model
  import scb_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Write-back from the slice
  input wire logic destination_write,
  input wire logic [63:0] destination_register,
  // Current destination contents
  output logic [63:0] destination_old
);
  // ------------------------------------------------------------
  // Destination entry
  // ------------------------------------------------------------
  typedef struct packed {
    logic [63:0] entry;
  } scb_pipe_state_t;

  scb_pipe_state_t st_r;
  scb_pipe_state_t st_nxt;

  // A skipped write must leave the old value, so only the strobe loads.
  always_comb begin
    st_nxt = st_r;
    if (destination_write) begin
      st_nxt.entry = destination_register;
    end
  end

  // Reset clears the entry to the same value the slice shows in reset.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_r <= '{entry: SCB_RESULT_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign destination_old = st_r.entry;
endmodule

// file: shift_cmove_bytecmp_unit_bench.sv
// Self-checking bench for the shift, move and byte compare slice.
// Assumes the slice answers one cycle after each accepted issue.
`timescale 1ns/1ps
module shift_cmove_bytecmp_unit_bench;
  import scb_pkg::*;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic issue_valid = 1'b0;
  logic [3:0] op_select = 4'h0;
  logic [63:0] first_source_operand = 64'h0;
  logic [63:0] second_source_operand = 64'h0;
  logic [7:0] literal_value = 8'h00;
  logic use_literal = 1'b0;
  logic [63:0] destination_old;
  logic result_valid;
  logic destination_write;
  logic exception_flag;
  logic [63:0] destination_register;
  logic [63:0] shadow = 64'h0;
  int miscompares = 0;
  int check_count = 0;

  // Clock toggles every half period of 25 ns.
  always #25 clock = ~clock;

  scb_unit dut (.clock(clock), .resetn(resetn), .issue_valid(issue_valid),
    .op_select(op_select), .first_source_operand(first_source_operand),
    .second_source_operand(second_source_operand),
    .literal_value(literal_value), .use_literal(use_literal),
    .destination_old(destination_old), .result_valid(result_valid),
    .destination_write(destination_write),
    .destination_register(destination_register),
    .exception_flag(exception_flag));

  scb_pipe_model pipe (.clock(clock), .resetn(resetn),
    .destination_write(destination_write),
    .destination_register(destination_register),
    .destination_old(destination_old));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  // Case equality so that an unknown never passes as a match.
  task automatic check(input string what, input logic [63:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Presents one issue for a single cycle, returning at the result cycle.
  task automatic issue(input logic [3:0] op, input logic [63:0] a, b,
    input logic [7:0] lit, input logic ul);
    @(negedge clock);
    issue_valid = 1'b1;
    op_select = op;
    first_source_operand = a;
    second_source_operand = b;
    literal_value = lit;
    use_literal = ul;
    @(negedge clock);
    issue_valid = 1'b0;
  endtask

  // Judges the result cycle; the shadow tracks the destination entry.
  task automatic expect_res(input logic wr, input logic [63:0] val);
    check("result_valid", {63'h0, result_valid}, 64'h1);
    check("destination_write", {63'h0, destination_write}, {63'h0, wr});
    check("destination_register", destination_register, val);
    check("exception_flag", {63'h0, exception_flag}, 64'h0);
    if (wr) shadow = val;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Every test code against zero, negative odd and positive even values.
  task automatic t_cond_move();
    logic [63:0] av [3] = '{64'h0, 64'hFFFF_FFFF_FFFF_FFFF, 64'h2};
    logic [63:0] a;
    logic [63:0] b;
    logic hit;
    for (int k = 0; k < 3; k++) begin
      for (int c = 0; c < 8; c++) begin
        a = av[k];
        b = 64'hC0DE_0000_0000_0000 | 64'(c * 4 + k);
        case (c)
          0: hit = (a == 64'h0);
          1: hit = (a != 64'h0);
          2: hit = a[63];
          3: hit = a[63] || (a == 64'h0);
          4: hit = !a[63] && (a != 64'h0);
          5: hit = !a[63];
          6: hit = !a[0];
          default: hit = a[0];
        endcase
        issue(4'(c), a, b, 8'h00, 1'b0);
        expect_res(hit, hit ? b : shadow);
      end
    end
  endtask

  // Counts at both ends, with junk above bit 5 of the count operand.
  task automatic t_shift();
    logic [63:0] av [2] = '{64'h8000_0000_0000_00F1, 64'h4000_0000_0000_0003};
    logic [5:0] cv [3] = '{6'h00, 6'h01, 6'h3F};
    logic [63:0] a;
    logic [63:0] b;
    logic [63:0] fill;
    for (int k = 0; k < 2; k++) begin
      for (int n = 0; n < 3; n++) begin
        a = av[k];
        b = 64'hFFFF_FFFF_FFFF_FFC0 | 64'(cv[n]);
        issue(SCB_OP_SHIFT_LEFT_ZERO, a, b, 8'h00, 1'b0);
        expect_res(1'b1, a << cv[n]);
        issue(SCB_OP_SHIFT_RIGHT_ZERO, a, b, 8'h00, 1'b0);
        expect_res(1'b1, a >> cv[n]);
        // Vacated top bits must all copy the sign bit of a.
        fill = {64{a[63]}} & ~(64'hFFFF_FFFF_FFFF_FFFF >> cv[n]);
        issue(SCB_OP_SHIFT_RIGHT_SIGN, a, b, 8'h00, 1'b0);
        expect_res(1'b1, (a >> cv[n]) | fill);
      end
    end
  endtask

  // Literal replaces the register operand and is zero-extended.
  task automatic t_literal();
    issue(SCB_OP_SHIFT_LEFT_ZERO, 64'h1, 64'h7, 8'hC5, 1'b1);
    expect_res(1'b1, 64'h20);
    issue(SCB_OP_SHIFT_RIGHT_ZERO, 64'h8000_0000_0000_0000, 64'h1,
      8'hFF, 1'b1);
    expect_res(1'b1, 64'h1);
    issue(SCB_OP_SHIFT_RIGHT_SIGN, 64'h8000_0000_0000_0000, 64'h0,
      8'h7C, 1'b1);
    expect_res(1'b1, 64'hFFFF_FFFF_FFFF_FFF8);
    issue(SCB_OP_MOVE_IF_ZERO, 64'h0, 64'hFFFF_FFFF_FFFF_FFFF, 8'h9C, 1'b1);
    expect_res(1'b1, 64'h9C);
    issue(SCB_OP_LANE_GE_COMPARE, 64'h10, 64'h0, 8'h80, 1'b1);
    expect_res(1'b1, 64'hFE);
  endtask

  // Lanes straddle the signed boundary, so a signed compare shows.
  task automatic t_compare();
    issue(SCB_OP_LANE_GE_COMPARE, 64'h00FF_7F80_0102_FE00,
      64'h0100_807F_0101_FF00, 8'h00, 1'b0);
    expect_res(1'b1, 64'h5D);
    issue(SCB_OP_LANE_GE_COMPARE, 64'hFFFF_FFFF_FFFF_FFFF,
      64'hFFFF_FFFF_FFFF_FFFF, 8'h00, 1'b0);
    expect_res(1'b1, 64'hFF);
    issue(SCB_OP_LANE_GE_COMPARE, 64'h0, 64'h0101_0101_0101_0100, 8'h00, 1'b0);
    expect_res(1'b1, 64'h01);
  endtask

  // Two issues on adjacent edges, then an unused code that never writes.
  task automatic t_back_to_back();
    @(negedge clock);
    issue_valid = 1'b1;
    op_select = SCB_OP_SHIFT_LEFT_ZERO;
    first_source_operand = 64'h1;
    second_source_operand = 64'h4;
    use_literal = 1'b0;
    @(negedge clock);
    op_select = SCB_OP_LANE_GE_COMPARE;
    second_source_operand = 64'h0202_0202_0202_0202;
    expect_res(1'b1, 64'h10);
    @(negedge clock);
    issue_valid = 1'b0;
    expect_res(1'b1, 64'h00);
    issue(4'hC, 64'h5, 64'h6, 8'h00, 1'b0);
    expect_res(1'b0, shadow);
  endtask

  // ------------------------------------------------------------
  // Sequence, verdict and watchdog
  // ------------------------------------------------------------
  task automatic results();
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Reset for two cycles, then the scenarios in turn.
  initial begin
    repeat (2) @(negedge clock);
    resetn = 1'b1;
    check("idle_valid", {63'h0, result_valid}, 64'h0);
    check("idle_data", destination_register, 64'h0);
    t_cond_move();
    t_shift();
    t_literal();
    t_compare();
    t_back_to_back();
    repeat (2) @(negedge clock);
    results();
  end

  // The run needs about 100 cycles; twenty times that means a hang.
  initial begin
    repeat (2000) @(posedge clock);
    miscompares++;
    results();
  end
endmodule
